/* File: rtl/strobed_fifo_pkg.sv */
// Shared constants and types for the strobed 256x18 FIFO
package strobed_fifo_pkg;
   // Storage geometry
   localparam int FIFO_DEPTH = 256;
   localparam int FIFO_WIDTH = 18;
   localparam int PTR_W = 8;
   localparam int CNT_W = 9;
   localparam int OFS_W = 7;
   // Flag thresholds and reset values
   localparam logic [8:0] HALF_LEVEL = 9'h080;
   localparam logic [6:0] OFS_DEFAULT = 7'h20;
   // Register offsets of the status port
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam logic [3:0] OFFSET_ADDR = 4'h8;
   localparam int CTRL_HOLD_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Offset programming sequence after reset
   typedef enum logic [1:0] {PROG_FIRST, PROG_SECOND, PROG_DONE} prog_state_t;
endpackage : strobed_fifo_pkg

/* File: rtl/fifo_word_store.sv */
// Dual-port word store with registered read data and write bypass
`timescale 1ns/1ns
module fifo_word_store
   import strobed_fifo_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH,
   parameter int AW = PTR_W
) (
   input wire logic sys_clk_in, // System clock
   input wire logic wr_en_in, // Store one word
   input wire logic [AW-1:0] wr_addr_in, // Write address
   input wire logic [WIDTH-1:0] wr_data_in, // Write word
   input wire logic [AW-1:0] rd_addr_in, // Head address for next cycle
   output logic [WIDTH-1:0] rd_data_out // Registered head word
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rd_data_reg;

   // Contents are never cleared, so the head word is undefined until loaded
   always_ff @(posedge sys_clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      // Bypass lets a word written into an empty queue fall through at once
      if (wr_en_in && wr_addr_in == rd_addr_in) begin
         rd_data_reg <= wr_data_in;
      end else begin
         rd_data_reg <= mem[rd_addr_in];
      end
   end

   assign rd_data_out = rd_data_reg;
endmodule : fifo_word_store

/* File: rtl/fifo_status_port.sv */
// AXI4-Lite slave giving software a control word and the FIFO status
`timescale 1ns/1ns
module fifo_status_port
   import strobed_fifo_pkg::*;
(
   input wire logic sys_clk_in, // System clock
   input wire logic reset_n_in, // Synchronous reset, active low
   input wire logic s_axi_awvalid_in, // Write address valid
   output logic s_axi_awready_out, // Write address ready
   input wire logic [3:0] s_axi_awaddr_in, // Write byte address
   input wire logic s_axi_wvalid_in, // Write data valid
   output logic s_axi_wready_out, // Write data ready
   input wire logic [31:0] s_axi_wdata_in, // Write data
   input wire logic [3:0] s_axi_wstrb_in, // Byte strobes
   output logic s_axi_bvalid_out, // Write response valid
   input wire logic s_axi_bready_in, // Write response ready
   output logic [1:0] s_axi_bresp_out, // Write response code
   input wire logic s_axi_arvalid_in, // Read address valid
   output logic s_axi_arready_out, // Read address ready
   input wire logic [3:0] s_axi_araddr_in, // Read byte address
   output logic s_axi_rvalid_out, // Read data valid
   input wire logic s_axi_rready_in, // Read data ready
   output logic [31:0] s_axi_rdata_out, // Read data
   output logic [1:0] s_axi_rresp_out, // Read response code
   input wire logic [31:0] status_in, // Live FIFO status word
   input wire logic [31:0] offsets_in, // Live offset word
   output logic [31:0] ctrl_out // Control register
);
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [3:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ctrl;
   } port_state_t;

   port_state_t s_reg, s_next;

   // Channels are held off while a response is waiting
   assign s_axi_awready_out = !s_reg.aw_got && !s_reg.bvalid;
   assign s_axi_wready_out = !s_reg.w_got && !s_reg.bvalid;
   assign s_axi_arready_out = !s_reg.rvalid;

   // Address and data may arrive in either order; write happens once both are held
   always_comb begin
      s_next = s_reg;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         s_next.aw_got = 1'b1;
         s_next.aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         s_next.w_got = 1'b1;
         s_next.w_data = s_axi_wdata_in;
         s_next.w_strb = s_axi_wstrb_in;
      end
      if (s_reg.bvalid && s_axi_bready_in) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.aw_got && s_reg.w_got) begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = RESP_SLVERR;
         if (s_reg.aw_addr == CTRL_ADDR) begin
            s_next.bresp = RESP_OKAY;
            for (int i = 0; i < 4; i++) begin
               if (s_reg.w_strb[i]) begin
                  s_next.ctrl[8*i +: 8] = s_reg.w_data[8*i +: 8];
               end
            end
         end else if (s_reg.aw_addr == STATUS_ADDR || s_reg.aw_addr == OFFSET_ADDR) begin
            s_next.bresp = RESP_OKAY; // Read-only words ignore writes
         end
      end
      if (s_reg.rvalid && s_axi_rready_in) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = RESP_OKAY;
         case (s_axi_araddr_in)
            CTRL_ADDR: s_next.rdata = s_reg.ctrl;
            STATUS_ADDR: s_next.rdata = status_in;
            OFFSET_ADDR: s_next.rdata = offsets_in;
            default: begin
               s_next.rdata = 32'h0000_0000;
               s_next.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   // Register the port state
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         s_reg <= '0;
         s_reg.ctrl <= CTRL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign s_axi_bvalid_out = s_reg.bvalid;
   assign s_axi_bresp_out = s_reg.bresp;
   assign s_axi_rvalid_out = s_reg.rvalid;
   assign s_axi_rdata_out = s_reg.rdata;
   assign s_axi_rresp_out = s_reg.rresp;
   assign ctrl_out = s_reg.ctrl;
endmodule : fifo_status_port

/* File: rtl/strobed_fifo_256x18_prog_flags.sv */
// Strobed 256x18 FIFO with full, empty, half-full and programmable almost flags
//
// How it works
// - Store 256 words of 18 bits
// - Load edge stores word unless full
// - Unload edge advances head unless empty
// - Full once loads exceed unloads by 256
// - Edges into full or empty change nothing
// - Full flag low at 256 words
// - Empty flag low at zero words
// - Half flag high from 128 words
// - Almost flag at or beyond either offset
// - First load edges program offsets when enabled
// - Programming only before first data word
// - First programming edge sets both offsets
// - Second programming edge sets high offset only
// - Programming edges never enter the queue
// - Offsets are 7-bit, up to 127
// - Enable held high keeps default 32
// - Reset clears pointers and sets flags
// - Almost flag high after reset
// - Read data not reset
// - First word falls through to outputs
// - Data not inverted, off while disabled
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module strobed_fifo_256x18_prog_flags
   import strobed_fifo_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic sys_clk_in, // System clock, 50 MHz
   input wire logic reset_n_in, // Synchronous reset, active low
   input wire logic load_strobe_in, // Rising edge loads a word
   input wire logic unload_strobe_in, // Rising edge unloads a word
   input wire logic offset_program_enable_n_in, // Offset programming, active low
   input wire logic output_enable_n_in, // Read data drive, active low
   input wire logic [WIDTH-1:0] write_data_in, // Word to load
   output logic [WIDTH-1:0] read_data_out, // Head word
   output logic read_data_oe_out, // High while read data are driven
   output logic full_n_out, // Low when full
   output logic empty_n_out, // Low when empty
   output logic half_full_flag_out, // High from half occupancy
   output logic almost_boundary_flag_out, // High near either end
   input wire logic s_axi_awvalid_in, // Write address valid
   output logic s_axi_awready_out, // Write address ready
   input wire logic [3:0] s_axi_awaddr_in, // Write byte address
   input wire logic s_axi_wvalid_in, // Write data valid
   output logic s_axi_wready_out, // Write data ready
   input wire logic [31:0] s_axi_wdata_in, // Write data
   input wire logic [3:0] s_axi_wstrb_in, // Byte strobes
   output logic s_axi_bvalid_out, // Write response valid
   input wire logic s_axi_bready_in, // Write response ready
   output logic [1:0] s_axi_bresp_out, // Write response code
   input wire logic s_axi_arvalid_in, // Read address valid
   output logic s_axi_arready_out, // Read address ready
   input wire logic [3:0] s_axi_araddr_in, // Read byte address
   output logic s_axi_rvalid_out, // Read data valid
   input wire logic s_axi_rready_in, // Read data ready
   output logic [31:0] s_axi_rdata_out, // Read data
   output logic [1:0] s_axi_rresp_out // Read response code
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

   typedef struct packed {
      logic ld_prev;
      logic un_prev;
      logic [AW-1:0] wr_gray;
      logic [AW-1:0] rd_gray;
      logic [CW-1:0] count;
      logic full_n;
      logic empty_n;
      logic half;
      logic almost;
      logic [OFS_W-1:0] ofs_low;
      logic [OFS_W-1:0] ofs_high;
      prog_state_t prog;
   } fifo_state_t;

   fifo_state_t s_reg, s_next;
   logic ld_edge, un_edge, prog_edge, do_load, do_unload;
   logic [AW-1:0] wr_bin, rd_bin, rd_addr;
   logic [31:0] ctrl_word;
   logic unload_hold;

   function automatic logic [AW-1:0] to_gray(input logic [AW-1:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray

   function automatic logic [AW-1:0] from_gray(input logic [AW-1:0] g);
      logic [AW-1:0] b;
      b[AW-1] = g[AW-1];
      for (int i = AW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : from_gray

   // Strobe edges and the decisions they trigger
   always_comb begin
      ld_edge = load_strobe_in && !s_reg.ld_prev;
      un_edge = unload_strobe_in && !s_reg.un_prev;
      wr_bin = from_gray(s_reg.wr_gray);
      rd_bin = from_gray(s_reg.rd_gray);
      unload_hold = ctrl_word[CTRL_HOLD_BIT];
      // Only the edges before any data word may program offsets
      prog_edge = ld_edge && !offset_program_enable_n_in && s_reg.prog != PROG_DONE;
      do_load = ld_edge && !prog_edge && s_reg.full_n;
      do_unload = un_edge && s_reg.empty_n && !unload_hold;
      rd_addr = do_unload ? rd_bin + AW'(1) : rd_bin;
   end

   // Next state: pointers, occupancy, flags and offset programming
   always_comb begin
      s_next = s_reg;
      s_next.ld_prev = load_strobe_in;
      s_next.un_prev = unload_strobe_in;
      if (prog_edge) begin
         if (s_reg.prog == PROG_FIRST) begin
            s_next.ofs_low = write_data_in[OFS_W-1:0];
            s_next.ofs_high = write_data_in[OFS_W-1:0];
            s_next.prog = PROG_SECOND;
         end else begin
            s_next.ofs_high = write_data_in[OFS_W-1:0];
            s_next.prog = PROG_DONE;
         end
      end else if (ld_edge) begin
         s_next.prog = PROG_DONE;
      end
      if (do_load) begin
         s_next.wr_gray = to_gray(wr_bin + AW'(1));
      end
      if (do_unload) begin
         s_next.rd_gray = to_gray(rd_bin + AW'(1));
      end
      case ({do_load, do_unload})
         2'b10: s_next.count = s_reg.count + CW'(1);
         2'b01: s_next.count = s_reg.count - CW'(1);
         default: s_next.count = s_reg.count;
      endcase
      // Flags are derived from the settled occupancy so they move with the data
      s_next.full_n = s_next.count != DEPTH_C;
      s_next.empty_n = s_next.count != '0;
      s_next.half = s_next.count >= CW'(HALF_LEVEL);
      s_next.almost = (s_next.count <= CW'(s_next.ofs_low)) ||
         (s_next.count >= DEPTH_C - CW'(s_next.ofs_high));
   end

   // Register the FIFO state; reset leaves the word store alone
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         s_reg <= '0;
         s_reg.full_n <= 1'b1;
         s_reg.almost <= 1'b1;
         s_reg.ofs_low <= OFS_DEFAULT;
         s_reg.ofs_high <= OFS_DEFAULT;
         s_reg.prog <= PROG_FIRST;
         s_reg.ld_prev <= 1'b1; // A strobe high at release is not an edge
         s_reg.un_prev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Word store; read data come from its output register, not reset
   fifo_word_store #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_store (
      .sys_clk_in(sys_clk_in),
      .wr_en_in(do_load),
      .wr_addr_in(wr_bin),
      .wr_data_in(write_data_in),
      .rd_addr_in(rd_addr),
      .rd_data_out(read_data_out)
   );

   // Software can pause unloads and observe occupancy and offsets
   fifo_status_port u_port (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .s_axi_awvalid_in(s_axi_awvalid_in),
      .s_axi_awready_out(s_axi_awready_out),
      .s_axi_awaddr_in(s_axi_awaddr_in),
      .s_axi_wvalid_in(s_axi_wvalid_in),
      .s_axi_wready_out(s_axi_wready_out),
      .s_axi_wdata_in(s_axi_wdata_in),
      .s_axi_wstrb_in(s_axi_wstrb_in),
      .s_axi_bvalid_out(s_axi_bvalid_out),
      .s_axi_bready_in(s_axi_bready_in),
      .s_axi_bresp_out(s_axi_bresp_out),
      .s_axi_arvalid_in(s_axi_arvalid_in),
      .s_axi_arready_out(s_axi_arready_out),
      .s_axi_araddr_in(s_axi_araddr_in),
      .s_axi_rvalid_out(s_axi_rvalid_out),
      .s_axi_rready_in(s_axi_rready_in),
      .s_axi_rdata_out(s_axi_rdata_out),
      .s_axi_rresp_out(s_axi_rresp_out),
      .status_in({17'h0_0000, s_reg.prog, s_reg.almost, s_reg.half, s_reg.empty_n,
                  s_reg.full_n, s_reg.count}),
      .offsets_in({16'h0000, 1'b0, s_reg.ofs_high, 1'b0, s_reg.ofs_low}),
      .ctrl_out(ctrl_word)
   );

   // Flag outputs and the read data drive
   assign full_n_out = s_reg.full_n;
   assign empty_n_out = s_reg.empty_n;
   assign half_full_flag_out = s_reg.half;
   assign almost_boundary_flag_out = s_reg.almost;
   assign read_data_oe_out = !output_enable_n_in;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_first_prog;
      ld_edge && s_reg.prog == PROG_FIRST && !offset_program_enable_n_in;
   endsequence
   sequence s_second_prog;
      ld_edge && s_reg.prog == PROG_SECOND && !offset_program_enable_n_in;
   endsequence

   property p_load_count;
      do_load && !do_unload |=> s_reg.count == $past(s_reg.count) + CW'(1);
   endproperty
   a_load_count: assert property (p_load_count) else $error("load did not add a word");
   property p_full_block;
      ld_edge && !full_n_out && !un_edge |=> $stable(s_reg.wr_gray) && !full_n_out;
   endproperty
   a_full_block: assert property (p_full_block) else $error("load while full moved pointer");
   property p_empty_block;
      un_edge && !empty_n_out |=> $stable(s_reg.rd_gray);
   endproperty
   a_empty_block: assert property (p_empty_block) else $error("unload while empty moved pointer");
   property p_flags;
      (full_n_out == (s_reg.count != DEPTH_C)) && (empty_n_out == (s_reg.count != '0)) &&
      (half_full_flag_out == (s_reg.count >= CW'(128)));
   endproperty
   a_flags: assert property (p_flags) else $error("flag disagrees with occupancy");
   property p_almost;
      almost_boundary_flag_out == ((s_reg.count <= CW'(s_reg.ofs_low)) ||
         (CW'(s_reg.count + CW'(s_reg.ofs_high)) >= DEPTH_C && s_reg.count != '0) ||
         (s_reg.count == DEPTH_C));
   endproperty
   a_almost: assert property (p_almost) else $error("almost flag wrong");
   property p_prog_first;
      s_first_prog |=> s_reg.ofs_low == $past(write_data_in[6:0]) &&
         s_reg.ofs_high == $past(write_data_in[6:0]) && $stable(s_reg.wr_gray);
   endproperty
   a_prog_first: assert property (p_prog_first) else $error("first offset edge wrong");
   property p_prog_second;
      s_second_prog |=> s_reg.ofs_high == $past(write_data_in[6:0]) && $stable(s_reg.ofs_low) &&
         $stable(s_reg.wr_gray);
   endproperty
   a_prog_second: assert property (p_prog_second) else $error("second offset edge wrong");
   property p_fall_through;
      do_load && s_reg.count == '0 |=> empty_n_out && read_data_out == $past(write_data_in);
   endproperty
   a_fall_through: assert property (p_fall_through) else $error("first word did not fall through");
   property p_gray_step;
      ##1 $onehot0(s_reg.wr_gray ^ $past(s_reg.wr_gray)) && $onehot0(s_reg.rd_gray ^ $past(s_reg.rd_gray));
   endproperty
   a_gray_step: assert property (p_gray_step) else $error("pointer changed more than one bit");
   property p_reset_flags;
      @(posedge sys_clk_in) disable iff (1'b0)
      !reset_n_in |=> full_n_out && !empty_n_out && !half_full_flag_out && almost_boundary_flag_out;
   endproperty
   a_reset_flags: assert property (p_reset_flags) else $error("reset flag values wrong");
   property p_oe;
      read_data_oe_out != output_enable_n_in;
   endproperty
   a_oe: assert property (p_oe) else $error("output enable inverted");
endmodule : strobed_fifo_256x18_prog_flags

/* File: tb/strobe_partner.sv */
// Writer and reader systems that drive the FIFO strobes
`timescale 1ns/1ns
module strobe_partner
   import strobed_fifo_pkg::*;
(
   input wire logic sys_clk_in, // Bench clock
   output logic load_strobe_out, // Load strobe
   output logic unload_strobe_out, // Unload strobe
   output logic prog_n_out, // Offset programming enable, active low
   output logic [FIFO_WIDTH-1:0] data_out // Word to load
);
   // Strobes rest low so the first rise after reset is a real edge
   initial begin
      load_strobe_out = 1'b0;
      unload_strobe_out = 1'b0;
      prog_n_out = 1'b1;
      data_out = '0;
   end

   // Enable only moves while the load strobe is low
   task automatic set_prog(input logic v);
      @(posedge sys_clk_in);
      prog_n_out <= v;
   endtask : set_prog

   // Word set up in the low phase; gap models a slow writer
   task automatic load_word(input logic [FIFO_WIDTH-1:0] d, input int gap);
      repeat (gap + 1) @(posedge sys_clk_in);
      data_out <= d;
      @(posedge sys_clk_in);
      load_strobe_out <= 1'b1;
      @(posedge sys_clk_in);
      load_strobe_out <= 1'b0;
      data_out <= ~d; // Hold over, the line no longer shows the word
   endtask : load_word

   // One low sample between edges keeps every rise visible
   task automatic unload_word(input int gap);
      repeat (gap + 1) @(posedge sys_clk_in);
      unload_strobe_out <= 1'b1;
      @(posedge sys_clk_in);
      unload_strobe_out <= 1'b0;
   endtask : unload_word
endmodule : strobe_partner

/* File: tb/strobed_fifo_256x18_prog_flags_tb.sv */
// Self-checking bench for the strobed 256x18 FIFO
`timescale 1ns/1ns
module strobed_fifo_256x18_prog_flags_tb
   import strobed_fifo_pkg::*;
;
   logic sys_clk_in, reset_n_in, output_enable_n_in;
   logic load_s, unload_s, prog_n;
   logic [FIFO_WIDTH-1:0] wdat, read_data_out;
   logic read_data_oe_out, full_n_out, empty_n_out, half_full_flag_out, almost_boundary_flag_out;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val;
   logic [1:0] bresp, rresp;
   int num_errors, tests_run;
   int lo_ofs, hi_ofs;

   strobe_partner u_partner (.sys_clk_in(sys_clk_in), .load_strobe_out(load_s), .unload_strobe_out(unload_s),
      .prog_n_out(prog_n), .data_out(wdat));

   strobed_fifo_256x18_prog_flags DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .load_strobe_in(load_s), .unload_strobe_in(unload_s), .offset_program_enable_n_in(prog_n),
      .output_enable_n_in(output_enable_n_in), .write_data_in(wdat), .read_data_out(read_data_out),
      .read_data_oe_out(read_data_oe_out), .full_n_out(full_n_out), .empty_n_out(empty_n_out),
      .half_full_flag_out(half_full_flag_out), .almost_boundary_flag_out(almost_boundary_flag_out),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
      .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));

   // Clock at 50 MHz
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check_val

   function automatic logic [FIFO_WIDTH-1:0] word(input int i);
      return FIFO_WIDTH'(i) ^ 18'h2a5a5;
   endfunction : word

   // Flags settle one cycle after the strobe edge, so look just past the edge
   task automatic chk_flags(input int cnt);
      #1;
      check_val(32'(full_n_out), 32'(cnt != 256));
      check_val(32'(empty_n_out), 32'(cnt != 0));
      check_val(32'(half_full_flag_out), 32'(cnt >= 128));
      check_val(32'(almost_boundary_flag_out), 32'(cnt <= lo_ofs || cnt >= 256 - hi_ofs));
   endtask : chk_flags

   // Write: address and data offered together, each dropped once taken
   // Handshakes are judged mid-cycle, where ready and valid are settled, then acted on at the edge
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      logic aw_hs, w_hs, b_hs;
      logic [1:0] resp;
      @(posedge sys_clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge sys_clk_in);
         aw_hs = awvalid && awready;
         w_hs = wvalid && wready;
         b_hs = bvalid;
         resp = bresp;
         @(posedge sys_clk_in);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) break;
      end
      if (n == 50) num_errors++;
      bready <= 1'b0;
      check_val(32'(resp), 32'(RESP_OKAY));
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, input logic [1:0] exp_resp);
      int n;
      logic ar_hs, r_hs;
      logic [1:0] resp;
      @(posedge sys_clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge sys_clk_in);
         ar_hs = arvalid && arready;
         r_hs = rvalid;
         rd_val = rdata;
         resp = rresp;
         @(posedge sys_clk_in);
         if (ar_hs) arvalid <= 1'b0;
         if (r_hs) break;
      end
      if (n == 50) num_errors++;
      rready <= 1'b0;
      check_val(32'(resp), 32'(exp_resp));
   endtask : axi_rd

   task automatic do_reset;
      @(posedge sys_clk_in);
      reset_n_in <= 1'b0;
      repeat (16) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      lo_ofs = 32;
      hi_ofs = 32;
   endtask : do_reset

   // Defaults after reset, unmapped access, one word with enable held high
   task automatic t_defaults;
      chk_flags(0);
      axi_rd(STATUS_ADDR, RESP_OKAY);
      check_val(rd_val, 32'h0000_1200);
      axi_rd(4'hc, RESP_SLVERR);
      check_val(rd_val, 32'h0);
      u_partner.load_word(18'h3fffe, 0);
      chk_flags(1);
      check_val(32'(read_data_out), 32'h3fffe);
      axi_rd(OFFSET_ADDR, RESP_OKAY);
      check_val(rd_val, 32'h0000_2020);
   endtask : t_defaults

   // Two programming edges: both offsets, then the high one alone
   task automatic t_program;
      do_reset();
      u_partner.set_prog(1'b0);
      u_partner.load_word(18'h3ff85, 0);
      axi_rd(OFFSET_ADDR, RESP_OKAY);
      check_val(rd_val, 32'h0000_0505);
      u_partner.load_word(18'h2ffff, 2);
      u_partner.set_prog(1'b1);
      lo_ofs = 5;
      hi_ofs = 127;
      chk_flags(0);
      axi_rd(OFFSET_ADDR, RESP_OKAY);
      check_val(rd_val, 32'h0000_7f05);
   endtask : t_program

   // Fill to the brim, then a refused load
   task automatic t_fill;
      for (int i = 0; i < 256; i++) begin
         u_partner.load_word(word(i), i % 3);
         chk_flags(i + 1);
         if (i == 0) check_val(32'(read_data_out), 32'(word(0)));
      end
      u_partner.load_word(18'h15555, 0);
      chk_flags(256);
      axi_rd(STATUS_ADDR, RESP_OKAY);
      check_val(rd_val, 32'h0000_5d00);
   endtask : t_fill

   // Output enable, held unloads, drain in order, refused unload, fall-through again
   task automatic t_drain;
      @(posedge sys_clk_in);
      output_enable_n_in <= 1'b1;
      chk_flags(256);
      check_val(32'(read_data_oe_out), 32'h0);
      output_enable_n_in <= 1'b0;
      axi_wr(CTRL_ADDR, 32'h1);
      u_partner.unload_word(0);
      chk_flags(256);
      axi_wr(CTRL_ADDR, 32'h0);
      check_val(32'(read_data_oe_out), 32'h1);
      for (int i = 0; i < 256; i++) begin
         check_val(32'(read_data_out), 32'(word(i)));
         u_partner.unload_word(i % 2);
         chk_flags(255 - i);
      end
      u_partner.unload_word(0);
      chk_flags(0);
      u_partner.load_word(18'h0c3c3, 1);
      chk_flags(1);
      check_val(32'(read_data_out), 32'h0c3c3);
   endtask : t_drain

   task automatic print_verdict;
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   // Reset first, before any strobe activity
   initial begin
      num_errors = 0;
      tests_run = 0;
      reset_n_in = 1'b0;
      output_enable_n_in = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      lo_ofs = 32;
      hi_ofs = 32;
      repeat (16) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      t_defaults();
      t_program();
      t_fill();
      t_drain();
      print_verdict();
   end

   // Whole run needs under two thousand cycles; this bound catches a hang
   initial begin
      #500000;
      num_errors++;
      print_verdict();
   end
endmodule : strobed_fifo_256x18_prog_flags_tb
